/* hw/sfdr_params.svh */
// constants of the double-rate read front end: register offsets, reset values,
// opcodes, opcode lengths less one and address phase lengths; assumes it is included by its bare name
`ifndef SFDR_PARAMS_SVH
`define SFDR_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define SFDR_OFS_CTRL 8'h00
`define SFDR_OFS_DUMMY 8'h04
`define SFDR_OFS_BUSY 8'h08
`define SFDR_OFS_STATUS 8'h0C
`define SFDR_OFS_MEMADDR 8'h10
`define SFDR_OFS_MEMDATA 8'h14

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define SFDR_CTRL_FOURWIRE 0
`define SFDR_CTRL_QUADEN 1
`define SFDR_DUMMY_RST 16'h6648
`define SFDR_STAT_WIP 0
`define SFDR_STAT_CONT 1
`define SFDR_STAT_FRAME 2

// ----------------------------------------------------------------------------
// opcodes, mode byte, opcode length less one and address phase length, in link clocks
// ----------------------------------------------------------------------------
`define SFDR_OP_SINGLE 8'h0D
`define SFDR_OP_DUAL 8'hBD
`define SFDR_OP_QUAD 8'hED
`define SFDR_MODE_CONT 4'hA
`define SFDR_OPCYC_SPI 4'h7
`define SFDR_OPCYC_QPI 4'h1
`define SFDR_ADDRCYC_W1 4'hC
`define SFDR_ADDRCYC_W2 4'h6
`define SFDR_ADDRCYC_W4 4'h3

`endif

/* hw/sfdr_pkg.sv */
// types shared by the double-rate read front end
// assumes sfdr_params.svh supplies the numeric constants
package sfdr_pkg;

    // ------------------------------------------------------------------------
    // frame phases and bus widths
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {SFDR_CMD, SFDR_ADDR, SFDR_DUMMY, SFDR_DATA, SFDR_IGNORE} sfdr_state_t;
    typedef enum logic [1:0] {SFDR_W1, SFDR_W2, SFDR_W4} sfdr_width_t;

endpackage

/* hw/sfdr_read_front.sv */
// double-rate read front end of a serial flash: link-side frame engine plus register port
// assumes the host drives chip select and the link clock; link clock stands between frames
`timescale 1ns/10ps
`include "sfdr_params.svh"

module sfdr_read_front #(
    parameter int MEM_AW = 12
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic linkClk,
    input wire logic chipSelN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    output logic writeInProgress
);
    import sfdr_pkg::*;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // append one rising and one falling group, rising group above
    function automatic logic [23:0] appendPair(input logic [23:0] s, input logic [3:0] r,
                                               input logic [3:0] f, input sfdr_width_t w);
        logic [23:0] res;
        res = {s[21:0], r[0], f[0]};
        if (w == SFDR_W2)
        begin
            res = {s[19:0], r[1:0], f[1:0]};
        end
        else if (w == SFDR_W4)
        begin
            res = {s[15:0], r, f};
        end
        return res;
    endfunction

    // dummy count for a read kind; zero is taken as one so data never overlaps address
    function automatic logic [3:0] dummyFor(input logic [15:0] cfg, input logic four_wire_command_mode, input sfdr_width_t w);
        logic [3:0] n;
        n = cfg[3:0];
        if (four_wire_command_mode)
        begin
            n = cfg[15:12];
        end
        else if (w == SFDR_W2)
        begin
            n = cfg[7:4];
        end
        else if (w == SFDR_W4)
        begin
            n = cfg[11:8];
        end
        if (n == 4'h0)
        begin
            n = 4'h1;
        end
        return n;
    endfunction

    // place a right-aligned output group onto the data lines
    function automatic logic [3:0] placeGroup(input sfdr_width_t w, input logic [3:0] g);
        logic [3:0] p;
        p = {2'b00, g[0], 1'b0};
        if (w == SFDR_W2)
        begin
            p = {2'b00, g[1:0]};
        end
        else if (w == SFDR_W4)
        begin
            p = g;
        end
        return p;
    endfunction

    // ------------------------------------------------------------------------
    // register side (ref_clk)
    // ------------------------------------------------------------------------
    logic fourWire;
    logic quadEn;
    logic [15:0] dummyCfg;
    logic [15:0] busyCnt;
    logic [MEM_AW-1:0] loadAddr;
    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic [2:0] backSync1;
    logic [2:0] backSync2;
    logic rejPrev;
    logic [7:0] rejectCnt;
    logic contMode;
    logic rejTog;

    assign writeInProgress = (busyCnt != 16'h0000);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            fourWire <= 1'b0;
            quadEn <= 1'b0;
            dummyCfg <= `SFDR_DUMMY_RST;
        end
        else if (regWr && regAddr == `SFDR_OFS_CTRL)
        begin
            fourWire <= regWdata[`SFDR_CTRL_FOURWIRE];
            quadEn <= regWdata[`SFDR_CTRL_QUADEN];
        end
        else if (regWr && regAddr == `SFDR_OFS_DUMMY)
        begin
            dummyCfg <= regWdata[15:0];
        end
    end

    // stand-in for an internal program or erase cycle: counts down while busy
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            busyCnt <= 16'h0000;
        end
        else if (regWr && regAddr == `SFDR_OFS_BUSY)
        begin
            busyCnt <= regWdata[15:0];
        end
        else if (busyCnt != 16'h0000)
        begin
            busyCnt <= busyCnt - 16'h0001;
        end
    end

    // array load port; load only while no frame is open, the link reads asynchronously
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            loadAddr <= '0;
        end
        else if (regWr && regAddr == `SFDR_OFS_MEMADDR)
        begin
            loadAddr <= regWdata[MEM_AW-1:0];
        end
        else if (regWr && regAddr == `SFDR_OFS_MEMDATA)
        begin
            loadAddr <= loadAddr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (regWr && regAddr == `SFDR_OFS_MEMDATA)
        begin
            mem[loadAddr] <= regWdata[7:0];
        end
    end

    // link state back into ref_clk; reject events travel as a toggle
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            backSync1 <= 3'h0;
            backSync2 <= 3'h0;
            rejPrev <= 1'b0;
            rejectCnt <= 8'h00;
        end
        else
        begin
            backSync1 <= {rejTog, ~chipSelN, contMode};
            backSync2 <= backSync1;
            rejPrev <= backSync2[2];
            if (backSync2[2] != rejPrev)
            begin
                rejectCnt <= rejectCnt + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            regRdata <= 32'h0000_0000;
        end
        else if (regRd)
        begin
            unique case (regAddr)
                `SFDR_OFS_CTRL: regRdata <= {30'h0, quadEn, fourWire};
                `SFDR_OFS_DUMMY: regRdata <= {16'h0000, dummyCfg};
                `SFDR_OFS_BUSY: regRdata <= {16'h0000, busyCnt};
                `SFDR_OFS_STATUS: regRdata <= {16'h0000, rejectCnt, 5'h00, backSync2[1:0], writeInProgress};
                `SFDR_OFS_MEMADDR: regRdata <= {{(32-MEM_AW){1'b0}}, loadAddr};
                `SFDR_OFS_MEMDATA: regRdata <= {24'h000000, mem[loadAddr]};
                default: regRdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            regRdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // settings into the link domain
    // ------------------------------------------------------------------------
    // quasi-static settings: the two stages take the first two link clocks of a frame
    logic [19:0] fwdSync1;
    logic [19:0] fwdSync2;
    logic linkRst;
    logic wipLink;
    logic qpiLink;
    logic quadEnLink;
    logic [15:0] dummyLink;

    always_ff @(posedge linkClk)
    begin
        fwdSync1 <= {~rstn, writeInProgress, fourWire, quadEn, dummyCfg};
        fwdSync2 <= fwdSync1;
    end

    assign linkRst = fwdSync2[19];
    assign wipLink = fwdSync2[18];
    assign qpiLink = fwdSync2[17];
    assign quadEnLink = fwdSync2[16];
    assign dummyLink = fwdSync2[15:0];

    // ------------------------------------------------------------------------
    // frame engine (linkClk, cleared while chip select is high)
    // ------------------------------------------------------------------------
    sfdr_state_t state;
    logic [3:0] cnt;
    logic [7:0] opSh;
    logic [23:0] inSh;
    logic [3:0] riseHold;
    logic [3:0] fallHold;
    sfdr_width_t width;
    logic modeEn;
    logic [3:0] dummyN;
    logic [MEM_AW-1:0] readAddr;
    logic [7:0] outSh;
    logic [1:0] byteLeft;
    logic [1:0] modeLeft;
    logic [23:0] modeSh;
    sfdr_width_t contWidth;
    logic contQpi;

    logic [7:0] opFull;
    logic opLast;
    logic startCont;
    logic decOk;
    logic decMode;
    sfdr_width_t decWidth;
    logic [3:0] addrCyc;
    logic [23:0] addrNext;
    logic [23:0] modeNext;
    logic dataEdge;

    always_comb
    begin
        opFull = qpiLink ? {opSh[3:0], ioIn} : {opSh[6:0], ioIn[0]};
        opLast = (state == SFDR_CMD) && (cnt == (qpiLink ? `SFDR_OPCYC_QPI : `SFDR_OPCYC_SPI));
        startCont = (state == SFDR_CMD) && (cnt == 4'h0) && contMode && (contQpi == qpiLink);
        decOk = 1'b0;
        decMode = 1'b0;
        decWidth = SFDR_W1;
        if (qpiLink)
        begin
            decWidth = SFDR_W4;
            decOk = (opFull == `SFDR_OP_SINGLE) || (opFull == `SFDR_OP_QUAD);
            decMode = (opFull == `SFDR_OP_QUAD);
        end
        else if (opFull == `SFDR_OP_SINGLE)
        begin
            decOk = 1'b1;
        end
        else if (opFull == `SFDR_OP_DUAL)
        begin
            decOk = 1'b1;
            decMode = 1'b1;
            decWidth = SFDR_W2;
        end
        else if (opFull == `SFDR_OP_QUAD)
        begin
            decOk = quadEnLink;
            decMode = 1'b1;
            decWidth = SFDR_W4;
        end
        addrCyc = (width == SFDR_W1) ? `SFDR_ADDRCYC_W1 : (width == SFDR_W2) ? `SFDR_ADDRCYC_W2 : `SFDR_ADDRCYC_W4;
        addrNext = appendPair(inSh, riseHold, fallHold, width);
        modeNext = appendPair(modeSh, riseHold, fallHold, width);
        dataEdge = (state == SFDR_DATA) || ((state == SFDR_DUMMY) && (cnt == dummyN));
    end

    // falling-edge group of every cycle, consumed at the next rising edge
    always_ff @(negedge linkClk or posedge chipSelN)
    begin
        if (chipSelN)
        begin
            fallHold <= 4'h0;
        end
        else
        begin
            fallHold <= ioIn;
        end
    end

    always_ff @(posedge linkClk or posedge chipSelN)
    begin
        if (chipSelN)
        begin
            state <= SFDR_CMD;
            cnt <= 4'h0;
            opSh <= 8'h00;
            inSh <= 24'h000000;
            riseHold <= 4'h0;
            width <= SFDR_W1;
            modeEn <= 1'b0;
            dummyN <= 4'h1;
            readAddr <= '0;
            outSh <= 8'h00;
            byteLeft <= 2'h0;
            modeLeft <= 2'h0;
            modeSh <= 24'h000000;
        end
        else
        begin
            riseHold <= ioIn;
            if (modeLeft != 2'h0)
            begin
                modeSh <= modeNext;
                modeLeft <= modeLeft - 2'h1;
            end
            if (dataEdge)
            begin
                if (byteLeft == 2'h0)
                begin
                    outSh <= mem[readAddr];
                    readAddr <= readAddr + 1'b1;
                    byteLeft <= (width == SFDR_W1) ? 2'h3 : (width == SFDR_W2) ? 2'h1 : 2'h0;
                end
                else
                begin
                    outSh <= (width == SFDR_W1) ? {outSh[5:0], 2'b00} : {outSh[3:0], 4'h0};
                    byteLeft <= byteLeft - 2'h1;
                end
            end
            unique case (state)
                SFDR_CMD:
                begin
                    if (startCont)
                    begin
                        // this edge already carries the first address group
                        state <= wipLink ? SFDR_IGNORE : SFDR_ADDR;
                        width <= contWidth;
                        modeEn <= 1'b1;
                        dummyN <= dummyFor(dummyLink, contQpi, contWidth);
                        cnt <= 4'h1;
                    end
                    else if (opLast)
                    begin
                        state <= (!decOk || wipLink) ? SFDR_IGNORE : SFDR_ADDR;
                        width <= decWidth;
                        modeEn <= decMode;
                        dummyN <= dummyFor(dummyLink, qpiLink, decWidth);
                        cnt <= 4'h0;
                    end
                    else
                    begin
                        opSh <= opFull;
                        cnt <= cnt + 4'h1;
                    end
                end
                SFDR_ADDR:
                begin
                    if (cnt != 4'h0)
                    begin
                        inSh <= addrNext;
                    end
                    if (cnt == addrCyc)
                    begin
                        // first dummy edge: last falling group of the address lands here
                        readAddr <= addrNext[MEM_AW-1:0];
                        modeLeft <= !modeEn ? 2'h0 : (width == SFDR_W2) ? 2'h2 : 2'h1;
                        state <= SFDR_DUMMY;
                        cnt <= 4'h1;
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                SFDR_DUMMY:
                begin
                    if (cnt == dummyN)
                    begin
                        state <= SFDR_DATA;
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                SFDR_DATA:
                begin
                    state <= SFDR_DATA;
                end
                SFDR_IGNORE:
                begin
                    state <= SFDR_IGNORE;
                end
            endcase
        end
    end

    // continuous mode survives chip select; only device reset or a mode byte changes it
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            contMode <= 1'b0;
            contWidth <= SFDR_W1;
            contQpi <= 1'b0;
        end
        else if (!chipSelN && modeLeft == 2'h1)
        begin
            contMode <= (modeNext[7:4] == `SFDR_MODE_CONT);
            contWidth <= width;
            contQpi <= qpiLink;
        end
    end

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            rejTog <= 1'b0;
        end
        else if (!chipSelN && wipLink && (startCont || opLast))
        begin
            rejTog <= ~rejTog;
        end
    end

    // ------------------------------------------------------------------------
    // data lines: higher group while the clock is high, lower group while low
    // ------------------------------------------------------------------------
    logic [3:0] hiGroup;
    logic [3:0] loGroup;

    always_comb
    begin
        hiGroup = {3'b000, outSh[7]};
        loGroup = {3'b000, outSh[6]};
        if (width == SFDR_W2)
        begin
            hiGroup = {2'b00, outSh[7:6]};
            loGroup = {2'b00, outSh[5:4]};
        end
        else if (width == SFDR_W4)
        begin
            hiGroup = outSh[7:4];
            loGroup = outSh[3:0];
        end
    end

    // the state clears at once on chip select high, so drive stops without a pin gate
    assign ioOut = (state != SFDR_DATA) ? 4'h0 : placeGroup(width, linkClk ? hiGroup : loGroup);
    assign ioOe = (state != SFDR_DATA) ? 4'h0 : placeGroup(width, 4'hF);
endmodule

/* tb/sfdr_read_front_chk.sv */
// port checker of the double-rate read front end: register port and link pins
// assumes it is bound to sfdr_read_front and sees only that module's ports
`timescale 1ns/10ps
`include "sfdr_params.svh"
module sfdr_read_front_chk #(
    parameter int MEM_AW = 12
) (
    input logic ref_clk,
    input logic rstn,
    input logic [7:0] regAddr,
    input logic [31:0] regWdata,
    input logic regWr,
    input logic regRd,
    input logic [31:0] regRdata,
    input logic linkClk,
    input logic chipSelN,
    input logic [3:0] ioIn,
    input logic [3:0] ioOut,
    input logic [3:0] ioOe,
    input logic writeInProgress
);
    // ------
    // register side
    // ------
    sequence dummyWrite;
        regWr && regAddr == `SFDR_OFS_DUMMY;
    endsequence
    sequence dummyRead;
        regRd && regAddr == `SFDR_OFS_DUMMY;
    endsequence
    dummy_readback_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        dummyWrite ##2 dummyRead |=> regRdata[15:0] == $past(regWdata[15:0], 3))
        else $error("dummy setting did not read back");
    busy_sets_wip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWr && regAddr == `SFDR_OFS_BUSY && regWdata != 32'h0 |=> writeInProgress)
        else $error("busy write did not raise write in progress");
    busy_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWr && regAddr == `SFDR_OFS_BUSY && regWdata == 32'h0 |=> !writeInProgress)
        else $error("zero busy count left write in progress");
    wip_status_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regRd && regAddr == `SFDR_OFS_STATUS |=> regRdata[`SFDR_STAT_WIP] == $past(writeInProgress))
        else $error("status flag differs from write in progress");
    busy_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regRd && regAddr == `SFDR_OFS_BUSY |=> (regRdata != 32'h0) == $past(writeInProgress))
        else $error("remaining count disagrees with write in progress");
    // ------
    // link side; oe drop is asynchronous, so the fast clock watches it
    // ------
    cs_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        chipSelN |-> ioOe == 4'h0)
        else $error("lines driven while deselected");
    oe_holds_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ioOe != 4'h0 && !chipSelN) ##1 !chipSelN |-> $stable(ioOe))
        else $error("output enable changed inside a frame");
    oe_pattern_a: assert property (@(negedge linkClk) disable iff (!rstn)
        ioOe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal output enable pattern");
endmodule

/* tb/sfdr_host_model.sv */
// flash controller model: drives chip select, link clock and data lines
// assumes the bench calls its tasks; the link clock stands between frames
`timescale 1ns/10ps
module sfdr_host_model (
    output logic linkClk,
    output logic chipSelN,
    output logic [3:0] ioIn,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe
);
    logic [7:0] rx [$];
    logic [3:0] oeSeen;
    initial
    begin
        linkClk = 1'b0;
        chipSelN = 1'b1;
        ioIn = 4'hA;
        oeSeen = 4'h0;
    end
    function automatic logic [3:0] pick(input logic [3:0] s, input int w);
        return w == 1 ? {3'b0, s[1]} : (w == 2 ? {2'b0, s[1:0]} : s);
    endfunction
    // one link cycle: high group before the rising edge, low group before the falling edge
    task automatic cyc(input logic [3:0] hi, input logic [3:0] lo, output logic [3:0] sh, output logic [3:0] sl);
        ioIn = hi;
        #40;
        linkClk = 1'b1;
        #40;
        sh = ioOut;
        ioIn = lo;
        #40;
        linkClk = 0;
        #40;
        sl = ioOut;
        oeSeen = oeSeen | ioOe;
    endtask
    // released lines toggle so stale values never look valid
    task automatic freeClk(input int n);
        logic [3:0] s;
        repeat (n)
            cyc(~ioIn, ioIn, s, s);
    endtask
    // most significant group first; single-rate sends garbage on the falling half
    task automatic send(input logic [23:0] v, input int nb, input int w, input bit ddr);
        logic [3:0] hi, lo, s;
        for (int i = 0; i < nb; i += (ddr ? 2 * w : w))
        begin
            hi = 4'(v[23:20] >> (4 - w));
            v = v << w;
            lo = ~hi;
            if (ddr)
            begin
                lo = 4'(v[23:20] >> (4 - w));
                v = v << w;
            end
            cyc(hi, lo, s, s);
        end
    endtask
    // opcode 00 means continuous mode: the frame starts at the address
    task automatic frame(input logic [7:0] op, input bit wideOp, input int w, input logic [23:0] addr,
                         input int nMode, input logic [7:0] mode, input int nDum, input int nBytes);
        logic [3:0] sh, sl;
        logic [7:0] b;
        rx.delete();
        oeSeen = 4'h0;
        b = 8'h00;
        chipSelN = 1'b0;
        if (op != 8'h00)
            send({op, 16'h0}, 8, wideOp ? 4 : 1, 1'b0);
        send(addr, 24, w, 1'b1);
        send({mode, 16'h0}, nMode * 2 * w, w, 1'b1);
        freeClk(nDum - nMode);
        repeat (nBytes)
        begin
            for (int i = 0; i < 4 / w; i++)
            begin
                cyc(~ioIn, ioIn, sh, sl);
                b = (b << w) | 8'(pick(sh, w));
                b = (b << w) | 8'(pick(sl, w));
            end
            rx.push_back(b);
        end
        #40;
        chipSelN = 1'b1;
        #80;
    endtask
endmodule

/* tb/tb_sfdr_read_front.sv */
// self-checking bench of the double-rate read front end
// assumes the host model drives the link; array shrunk to 256 bytes
`timescale 1ns/10ps
`include "sfdr_params.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_sfdr_read_front;
    import sfdr_pkg::*;
    localparam int MEM_AW = 8;
    localparam logic [7:0] KOP [5] = '{8'h0D, 8'hBD, 8'hED, 8'h0D, 8'hED};
    localparam int KW [5] = '{1, 2, 4, 4, 4};
    localparam int KMODE [5] = '{0, 2, 1, 1, 1};
    localparam int KFLD [5] = '{0, 1, 2, 3, 3};
    localparam bit KFW [5] = '{0, 0, 0, 1, 1};
    localparam logic [3:0] KOE [5] = '{4'h2, 4'h3, 4'hF, 4'hF, 4'hF};
    logic ref_clk, rstn, regWr, regRd, linkClk, chipSelN, writeInProgress;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic [3:0] ioIn, ioOut, ioOe;
    logic [7:0] mem [256];
    logic [15:0] dum;
    int nErrors = 0;
    int nTests = 0;
    int seed = 17913;
    sfdr_read_front #(.MEM_AW(MEM_AW)) dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .linkClk(linkClk),
        .chipSelN(chipSelN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .writeInProgress(writeInProgress));
    sfdr_host_model host (.linkClk(linkClk), .chipSelN(chipSelN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] expByte(input logic [23:0] a, input int i);
        return mem[8'(a + 24'(i))];
    endfunction
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // settings need link edges to cross
    task automatic setCfg(input bit fw, input logic [15:0] d);
        dum = d;
        regWrite(`SFDR_OFS_CTRL, {30'h0, 1'b1, fw});
        regWrite(`SFDR_OFS_DUMMY, {16'h0, d});
        host.freeClk(3);
    endtask
    task automatic runKind(input int k, input logic [23:0] a, input logic [7:0] m, input bit skip, input bit on);
        int n;
        n = int'(dum[KFLD[k] * 4 +: 4]);
        host.frame(skip ? 8'h00 : KOP[k], KFW[k], KW[k], a, KMODE[k], m, n, 3);
        for (int i = 0; i < 3; i++)
            if (on)
                `CHK("data", expByte(a, i), host.rx[i])
        `CHK("oe", on ? KOE[k] : 4'h0, host.oeSeen)
    endtask
    task automatic tallyAndFinish;
        $display("comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #2000000;
        nErrors++;
        $display("FAIL watchdog expected done seen hang");
        tallyAndFinish();
    end
    initial
    begin
        logic [23:0] a;
        int ks [3];
        {rstn, regWr, regRd, regAddr, regWdata} = '0;
        fork
            host.freeClk(3);
            repeat (16) @(posedge ref_clk);
        join
        rstn <= 1'b1;
        // ------
        // registers
        // ------
        regRead(`SFDR_OFS_DUMMY, rd);
        `CHK("dummy reset", `SFDR_DUMMY_RST, rd[15:0])
        regRead(8'h40, rd);
        `CHK("unmapped", 32'h0, rd)
        regWrite(`SFDR_OFS_DUMMY, 32'h0000_5749);
        regRead(`SFDR_OFS_DUMMY, rd);
        `CHK("dummy write", 16'h5749, rd[15:0])
        regWrite(`SFDR_OFS_MEMADDR, 32'h0);
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 8'($random(seed));
            regWrite(`SFDR_OFS_MEMDATA, {24'h0, mem[i]});
        end
        $display("test registers done");
        // ------
        // every read kind, random and top address
        // ------
        for (int k = 0; k < 5; k++)
            for (int r = 0; r < 2; r++)
            begin
                for (int j = 0; j < 4; j++)
                    dum[j * 4 +: 4] = 4'(4 + ($unsigned($random(seed)) % 6));
                setCfg(KFW[k], dum);
                a = r ? {16'($random(seed)), 8'hFE} : 24'($random(seed));
                runKind(k, a, k == 3 ? 8'hA5 : 8'h5F, 1'b0, 1'b1);
                regRead(`SFDR_OFS_STATUS, rd);
                `CHK("no continuous", 1'b0, rd[`SFDR_STAT_CONT])
            end
        `CHK("idle oe", 4'h0, ioOe)
        $display("test read kinds done");
        // ------
        // continuous mode entry and exit
        // ------
        ks = '{1, 2, 4};
        foreach (ks[i])
        begin
            setCfg(KFW[ks[i]], `SFDR_DUMMY_RST);
            runKind(ks[i], 24'($random(seed)), 8'hA3, 1'b0, 1'b1);
            regRead(`SFDR_OFS_STATUS, rd);
            `CHK("enter continuous", 1'b1, rd[`SFDR_STAT_CONT])
            runKind(ks[i], 24'($random(seed)), 8'h3A, 1'b1, 1'b1);
            regRead(`SFDR_OFS_STATUS, rd);
            `CHK("leave continuous", 1'b0, rd[`SFDR_STAT_CONT])
            runKind(ks[i], 24'($random(seed)), 8'h5F, 1'b0, 1'b1);
        end
        $display("test continuous done");
        // ------
        // reads during an internal write cycle are refused
        // ------
        setCfg(1'b0, `SFDR_DUMMY_RST);
        regWrite(`SFDR_OFS_BUSY, 32'h5DC);
        host.freeClk(3);
        `CHK("wip set", 1'b1, writeInProgress)
        for (int k = 0; k < 3; k++)
            runKind(k, 24'($random(seed)), 8'h5F, 1'b0, 1'b0);
        regRead(`SFDR_OFS_STATUS, rd);
        `CHK("reject count", 8'h03, rd[15:8])
        `CHK("wip still", 1'b1, rd[`SFDR_STAT_WIP])
        for (int i = 0; i < 3000 && writeInProgress !== 1'b0; i++)
            @(posedge ref_clk);
        `CHK("wip clear", 1'b0, writeInProgress)
        regRead(`SFDR_OFS_BUSY, rd);
        `CHK("busy left", 32'h0, rd)
        regWrite(`SFDR_OFS_BUSY, 32'h0);
        host.freeClk(3);
        runKind(2, 24'($random(seed)), 8'h5F, 1'b0, 1'b1);
        $display("test write in progress done");
        tallyAndFinish();
    end
endmodule
bind sfdr_read_front sfdr_read_front_chk #(.MEM_AW(MEM_AW)) chk (.ref_clk(ref_clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .linkClk(linkClk), .chipSelN(chipSelN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .writeInProgress(writeInProgress));
